// ---- core/vpwc_pkg.sv ----
// vpwc_pkg: constants, register map and types for the pulse-width bus codec
// assumes a 125 MHz system clock and a 1 us symbol timing base
package vpwc_pkg;
	// ------------------------------------------------------------
	// timing base
	// ------------------------------------------------------------
	localparam int CLK_NS   = 8;
	localparam int TICK_NS  = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	// ------------------------------------------------------------
	// pulse-width thresholds, in timing-base counts
	// ------------------------------------------------------------
	localparam logic [9:0] T_IGN_MAX  = 10'h007;
	localparam logic [3:0] FILT_LAST  = 4'h7;
	localparam logic [9:0] T_INV_MAX  = 10'h022;
	localparam logic [9:0] T1_MAX     = 10'h060;
	localparam logic [9:0] T2_MAX     = 10'h0A3;
	localparam logic [9:0] T3_MAX     = 10'h0EF;
	localparam logic [9:0] T1_NOM     = 10'h040;
	localparam logic [9:0] T2_NOM     = 10'h080;
	localparam logic [9:0] T3_NOM     = 10'h0C8;
	localparam logic [9:0] T4_NOM     = 10'h118;
	localparam logic [9:0] T6_NOM     = 10'h12C;
	localparam logic [9:0] SYNC_MAX   = 10'h060;
	localparam logic [9:0] TMR_MAX    = 10'h3FF;
	// ------------------------------------------------------------
	// register map (byte addresses) and fields
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_STATUS   = 8'h04;
	localparam logic [7:0] A_TRANSMIT_BYTE_REGISTER   = 8'h08;
	localparam logic [7:0] A_TRANSMIT_OPCODE_REGISTER     = 8'h0C;
	localparam logic [7:0] A_RECEIVE_BYTE_REGISTER   = 8'h10;
	localparam logic [7:0] A_FILTER   = 8'h14;
	localparam int CTRL_EN   = 0;
	localparam int CTRL_INV  = 1;
	localparam int CTRL_DLY  = 2;
	localparam int CTRL_LAM  = 7;
	localparam int STAT_IBD  = 2;
	localparam int STAT_LOST = 3;
	localparam logic [1:0] OP_MSG  = 2'h1;
	localparam logic [1:0] OP_LAST = 2'h2;
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		E_IDLE = 2'b00,
		E_WAIT = 2'b01,
		E_ECHO = 2'b11,
		E_TIME = 2'b10
	} vpwc_enc_t;
	typedef enum logic [2:0] {
		C_INV  = 3'h0,
		C_T1   = 3'h1,
		C_T2   = 3'h2,
		C_T3   = 3'h3,
		C_LONG = 3'h4
	} vpwc_cls_t;
endpackage

// ---- core/vpwc_codec.sv ----
// vpwc_codec: pulse-width serial bus symbol encoder/decoder with APB registers
// assumes an external transceiver echoes bus_drive_output_out back on the input pin
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module vpwc_codec
	import vpwc_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYC
) (
	// clock, reset, enable
	input  wire logic        sys_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        ce_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// transceiver pins
	input  wire logic        bus_receive_input_in,
	output logic             bus_drive_output_out
);
	// ------------------------------------------------------------
	// checks and helpers
	// ------------------------------------------------------------
	if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_chk
		$error("vpwc_codec: TICK_DIV must be 1 to 256");
	end
	localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);
	localparam logic [9:0] FILT_DLY  = {6'h00, FILT_LAST} + 10'h001; // ticks an echo spends in the filter

	function automatic logic [7:0] vpwc_crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction
	function automatic vpwc_cls_t vpwc_classify(input logic [9:0] d);
		if (d <= T_INV_MAX) return C_INV;
		if (d <= T1_MAX) return C_T1;
		if (d <= T2_MAX) return C_T2;
		if (d <= T3_MAX) return C_T3;
		return C_LONG;
	endfunction
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic        sync1, sync2, rx_lvl, in_frame, suppress, gap_ok, own, first_seen;
		logic [7:0]  tick_cnt, rx_shift, rx_byte;
		logic [3:0]  filt_cnt, rx_bits;
		logic [9:0]  rx_timer, sym_len;
		logic [4:0]  frame_idx, loop_delay_field;
		logic        rx_full, invalid_bit_error_flag, lost, enable, invert, lamask;
		logic [7:0]  transmit_byte_register, tx_shift, crc;
		logic        pending, pend_last, tx_ready, is_sof, last, is_crc, sym_lvl, pbit, pbit_vld, drive;
		vpwc_enc_t   enc;
		logic [2:0]  bit_idx;
		logic [31:0] filter, prdata;
		logic        pready, pslverr;
	} vpwc_state_t;
	vpwc_state_t st;
	vpwc_state_t next_st;
	logic        raw_lvl, tick, edge_ev, ev_inv, ev_eof, got_bit, dbit, byte_done;
	logic        permit, lose, acc, wr, rd, sym_end, start, hit;
	logic [7:0]  bv, ns;
	logic [4:0]  fidx;
	logic [9:0]  target;
	logic [2:0]  ni;
	logic [31:0] rv;
	vpwc_cls_t   cls;
	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		// input pin: two flops, then polarity
		next_st.sync1 = bus_receive_input_in;
		next_st.sync2 = st.sync1;
		raw_lvl = st.sync2 ^ st.invert;
		tick = (st.tick_cnt == TICK_LAST);
		next_st.tick_cnt = tick ? 8'h00 : st.tick_cnt + 8'h01;
		edge_ev = 1'b0;
		// filter: a level must hold past the ignored width to count
		if (tick) begin
			if (st.rx_timer != TMR_MAX)
				next_st.rx_timer = st.rx_timer + 10'h001;
			if (raw_lvl != st.rx_lvl) begin
				next_st.filt_cnt = st.filt_cnt + 4'h1;
				if (st.filt_cnt == FILT_LAST) begin
					edge_ev = 1'b1;
					next_st.rx_lvl = raw_lvl;
					next_st.rx_timer = 10'h000;
					next_st.filt_cnt = 4'h0;
				end
			end else begin
				next_st.filt_cnt = 4'h0;
			end
		end
		// ------------------------------------------------------------
		// decoder
		// ------------------------------------------------------------
		cls = vpwc_classify(st.rx_timer);
		dbit = st.rx_lvl ? (cls == C_T1) : (cls == C_T2);
		ev_inv = 1'b0;
		got_bit = 1'b0;
		byte_done = 1'b0;
		if (edge_ev) begin
			next_st.gap_ok = !st.rx_lvl && (cls == C_LONG);
			case (cls)
				C_INV: begin
					ev_inv = 1'b1;
				end
				C_T1, C_T2: begin
					got_bit = st.in_frame;
				end
				C_T3: begin
					next_st.rx_bits = 4'h0;
					if (st.rx_lvl) begin
						next_st.in_frame = 1'b1;
						next_st.first_seen = 1'b0;
					end
				end
				default: begin
					if (st.rx_lvl)
						next_st.in_frame = 1'b0;
				end
			endcase
		end
		bv = {st.rx_shift[6:0], dbit};
		fidx = st.first_seen ? st.frame_idx : bv[7:3];
		permit = !st.own || st.filter[fidx];
		if (got_bit) begin
			next_st.rx_shift = bv;
			next_st.rx_bits = st.rx_bits + 4'h1;
			if (st.rx_bits == 4'h7) begin
				byte_done = 1'b1;
				next_st.rx_bits = 4'h0;
				next_st.first_seen = 1'b1;
				next_st.frame_idx = fidx;
			end
		end
		// passive beyond the longest Tv3 is an end of frame
		ev_eof = tick && !st.rx_lvl && !edge_ev && (st.rx_timer == T3_MAX);
		if (ev_eof) begin
			next_st.in_frame = 1'b0;
			next_st.suppress = 1'b0;
			next_st.own = 1'b0;
		end
		if (ev_inv) begin
			next_st.suppress = 1'b1;
			next_st.rx_bits = 4'h0;
		end
		// ------------------------------------------------------------
		// apb slave, one wait state
		// ------------------------------------------------------------
		acc = psel_in && penable_in && st.pready;
		wr = acc && pwrite_in;
		rd = acc && !pwrite_in;
		hit = 1'b1;
		case (paddr_in)
			A_CTRL:   rv = {24'h000000, st.lamask, st.loop_delay_field, st.invert, st.enable};
			A_STATUS: rv = {26'h0000000, st.in_frame, (st.enc != E_IDLE),
			                st.lost, st.invalid_bit_error_flag, st.rx_full, st.tx_ready};
			A_TRANSMIT_BYTE_REGISTER: rv = {24'h000000, st.transmit_byte_register};
			A_TRANSMIT_OPCODE_REGISTER:   rv = {30'h00000000, st.pend_last, st.pending};
			A_RECEIVE_BYTE_REGISTER: rv = {24'h000000, st.rx_byte};
			A_FILTER: rv = st.filter;
			default: begin
				rv = 32'h00000000;
				hit = 1'b0;
			end
		endcase
		next_st.pready = psel_in && penable_in && !st.pready;
		if (psel_in && penable_in && !st.pready) begin
			next_st.prdata = pwrite_in ? 32'h00000000 : rv;
			next_st.pslverr = !hit;
		end else if (!psel_in) begin
			next_st.pslverr = 1'b0;
		end
		// software clears first, so a hardware set in the same cycle wins
		if (wr && paddr_in == A_STATUS) begin
			if (pwdata_in[STAT_IBD])
				next_st.invalid_bit_error_flag = 1'b0;
			if (pwdata_in[STAT_LOST])
				next_st.lost = 1'b0;
		end
		if (rd && paddr_in == A_RECEIVE_BYTE_REGISTER)
			next_st.rx_full = 1'b0;
		if (wr && paddr_in == A_CTRL) begin
			next_st.enable = pwdata_in[CTRL_EN];
			next_st.invert = pwdata_in[CTRL_INV];
			next_st.loop_delay_field = pwdata_in[CTRL_DLY +: 5];
			next_st.lamask = pwdata_in[CTRL_LAM];
		end
		if (wr && paddr_in == A_TRANSMIT_BYTE_REGISTER)
			next_st.transmit_byte_register = pwdata_in[7:0];
		if (wr && paddr_in == A_FILTER)
			next_st.filter = pwdata_in;
		if (ev_inv)
			next_st.invalid_bit_error_flag = 1'b1;
		if (byte_done && permit && !st.suppress) begin
			next_st.rx_byte = bv;
			next_st.rx_full = 1'b1;
		end
		// ------------------------------------------------------------
		// encoder
		// ------------------------------------------------------------
		// echo lags by loop delay plus filter length, so end early by both
		target = (st.sym_len > {5'h00, st.loop_delay_field} + FILT_DLY)
			? st.sym_len - {5'h00, st.loop_delay_field} - FILT_DLY : 10'h001;
		sym_end = (st.enc == E_TIME) && (st.rx_timer >= target);
		// no start in the cycle an invalid bit aborts, nor while disabled
		start = !ev_inv && st.enable
			&& ((!st.rx_lvl && !st.in_frame && st.rx_timer >= T6_NOM)
			|| (st.rx_lvl && st.gap_ok && st.rx_timer <= SYNC_MAX));
		lose = 1'b0;
		ni = 3'h7;
		ns = st.tx_shift;
		case (st.enc)
			E_IDLE: begin
				if (st.pending && st.enable)
					next_st.enc = E_WAIT;
			end
			E_WAIT: begin
				if (start) begin
					next_st.tx_shift = st.transmit_byte_register;
					next_st.crc = vpwc_crc8(CRC_INIT, st.transmit_byte_register);
					next_st.last = st.pend_last;
					next_st.pending = 1'b0;
					next_st.tx_ready = 1'b1;
					next_st.is_crc = 1'b0;
					next_st.own = 1'b1;
					next_st.is_sof = 1'b1;
					next_st.pbit_vld = 1'b0;
					next_st.sym_lvl = 1'b1;
					next_st.sym_len = T3_NOM;
					next_st.drive = 1'b1;
					next_st.enc = E_ECHO;
				end
			end
			E_ECHO: begin
				// a winning zero from another node shows as a longer active pulse
				if (edge_ev && st.rx_lvl && !st.sym_lvl && st.pbit_vld
						&& dbit != st.pbit)
					lose = 1'b1;
				else if (st.rx_lvl == st.sym_lvl)
					next_st.enc = E_TIME;
			end
			E_TIME: begin
				if (edge_ev && !st.sym_lvl) begin
					lose = 1'b1;
				end else if (sym_end) begin
					next_st.pbit = st.tx_shift[st.bit_idx];
					next_st.pbit_vld = !st.is_sof;
					next_st.is_sof = 1'b0;
					if (st.is_sof) begin
						ni = 3'h7;
					end else if (st.bit_idx != 3'h0) begin
						ni = st.bit_idx - 3'h1;
					end else if (!st.is_crc && !st.last && st.pending) begin
						ns = st.transmit_byte_register;
						next_st.crc = vpwc_crc8(st.crc, st.transmit_byte_register);
						next_st.last = st.pend_last;
						next_st.pending = 1'b0;
						next_st.tx_ready = 1'b1;
					end else if (!st.is_crc) begin
						// an underrun ends the frame with the CRC as well
						ns = ~st.crc;
						next_st.is_crc = 1'b1;
					end
					if (!st.is_sof && st.bit_idx == 3'h0 && st.is_crc) begin
						// passive from here on forms the end of data
						next_st.drive = 1'b0;
						next_st.enc = E_IDLE;
					end else begin
						next_st.tx_shift = ns;
						next_st.bit_idx = ni;
						next_st.sym_lvl = ~ni[0];
						next_st.sym_len = (ns[ni] != ~ni[0]) ? T2_NOM : T1_NOM;
						next_st.drive = ~ni[0];
						next_st.enc = E_ECHO;
					end
				end
			end
			default: begin
				next_st.enc = E_IDLE;
			end
		endcase
		if (lose) begin
			next_st.lost = 1'b1;
			next_st.drive = 1'b0;
			next_st.enc = E_IDLE;
		end
		if ((ev_inv || !st.enable) && (st.enc == E_ECHO || st.enc == E_TIME)) begin
			next_st.drive = 1'b0;
			next_st.enc = E_IDLE;
		end
		// a new opcode joins the frame in flight, or queues behind it once that frame's last byte or CRC is under way
		if (wr && paddr_in == A_TRANSMIT_OPCODE_REGISTER
				&& (pwdata_in[1:0] == OP_MSG || pwdata_in[1:0] == OP_LAST)) begin
			next_st.pending = 1'b1;
			next_st.pend_last = (pwdata_in[1:0] == OP_LAST);
			next_st.tx_ready = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st <= '0;
			st.tx_ready <= 1'b1;
			st.rx_timer <= TMR_MAX;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign prdata_out = st.prdata;
	assign pready_out = st.pready;
	assign pslverr_out = st.pslverr;
	assign bus_drive_output_out = st.drive;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking vpwc_cb @(posedge sys_clk_in iff ce_in);
	endclocking
	default disable iff (!rstn_in);

	idle_passive_a: assert property (
		(st.enc == E_IDLE || st.enc == E_WAIT) |-> !st.drive)
		else $error("output active while encoder idle");
	filter_width_a: assert property (
		$changed(st.rx_lvl) |-> st.rx_timer == 10'h000 && $past(st.filt_cnt) == FILT_LAST)
		else $error("filtered level changed without a full filter run");
	invalid_abort_a: assert property (
		ev_inv |=> st.invalid_bit_error_flag && st.suppress && !st.drive)
		else $error("invalid bit did not flag and abort");
	suppress_rx_a: assert property (
		st.suppress |=> !$rose(st.rx_full))
		else $error("receive full set while muted");
	lost_passive_a: assert property (
		$rose(st.lost) |-> !st.drive && st.enc == E_IDLE)
		else $error("arbitration lost but output still driven");
	ifs_start_a: assert property (
		($past(st.enc) == E_WAIT && st.enc == E_ECHO && !$past(st.rx_lvl))
		|-> $past(st.rx_timer) >= T6_NOM && st.drive)
		else $error("frame started before inter-frame gap");
	sof_join_a: assert property (
		($past(st.enc) == E_WAIT && st.enc == E_ECHO && $past(st.rx_lvl))
		|-> $past(st.rx_timer) <= SYNC_MAX && st.is_sof)
		else $error("joined an incoming start too late");
	transmit_opcode_register_clear_a: assert property (
		(wr && paddr_in == A_TRANSMIT_OPCODE_REGISTER && pwdata_in[1:0] == OP_MSG) |=> !st.tx_ready ##1 1'b1)
		else $error("opcode write did not clear transmit ready");
	own_filter_a: assert property (
		(byte_done && st.own && !st.filter[fidx] && !st.rx_full) |=> !st.rx_full)
		else $error("own byte received although filtered out");
endmodule // vpwc_codec
`default_nettype wire

// ---- testbench/vpwc_xcvr.sv ----
// vpwc_xcvr: behavioural transceiver facing the codec's bus pins
// assumes one foreign node, given by the bench as an extra active driver
`timescale 1ns/100ps
`default_nettype none
module vpwc_xcvr #(
	parameter int DLY_NS = 80
) (
	// codec, foreign node and pin polarity
	input  wire logic drive_in,
	input  wire logic other_in,
	input  wire logic inv_in,
	// echoed line
	output logic      rx_out
);
	logic echo;
	initial echo = 1'b0;
	// transport delay, so even short edges come back in order
	always @(drive_in) echo <= #(DLY_NS) drive_in;
	// active dominates the wire; the pin may be inverted
	assign rx_out = inv_in ^ (echo | other_in);
endmodule // vpwc_xcvr
`default_nettype wire

// ---- testbench/vpwc_codec_test.sv ----
// vpwc_codec_test: register-level tests of the pulse-width bus codec
// assumes the transceiver model echoes the drive pin with a fixed delay
`timescale 1ns/100ps
`default_nettype none
module vpwc_codec_test;
	import vpwc_pkg::*;
	localparam int TD  = 2;
	localparam int DLY = 5;
	logic        sys_clk_in = 1'b0;
	logic        rstn_in    = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0;
	logic        other      = 1'b0;
	logic        inv        = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, drive, rx, last_err;
	int          num_errors = 0;
	int          total_checks = 0;
	int          pw[$];
	logic        pl[$];
	int          run = 0;
	logic        last_lvl = 1'b0;

	always #4 sys_clk_in = ~sys_clk_in;

	vpwc_codec #(.TICK_DIV(TD)) uut (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.bus_receive_input_in(rx), .bus_drive_output_out(drive)
	);
	vpwc_xcvr #(.DLY_NS(DLY * TD * 8)) xcvr (
		.drive_in(drive), .other_in(other), .inv_in(inv), .rx_out(rx)
	);

	// record each finished drive level with its length in cycles
	always @(posedge sys_clk_in) begin
		if (drive !== last_lvl) begin
			pw.push_back(run);
			pl.push_back(last_lvl);
			run = 1;
			last_lvl = drive;
		end else begin
			run++;
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task ticks(input int n);
		repeat (n * TD) @(posedge sys_clk_in);
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		// only the watchdog ends a wait for ready
		do begin
			@(posedge sys_clk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	task apb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		apb(1'b1, a, d, x);
	endtask

	task apb_rd(input logic [7:0] a, output logic [31:0] v);
		apb(1'b0, a, 32'h0, v);
	endtask

	task wait_lvl(input logic l, output int n);
		n = 0;
		while (drive !== l && n < 4000) begin
			@(posedge sys_clk_in);
			n++;
		end
		if (n >= 4000) num_errors++;
	endtask

	task wait_quiet;
		logic [31:0] v;
		int n;
		n = 0;
		ticks(4);
		do begin
			apb_rd(A_STATUS, v);
			n++;
		end while (v[4] !== 1'b0 && n < 3000);
		if (n >= 3000) num_errors++;
		ticks(320);
	endtask

	function automatic int cls(input int cyc);
		int t;
		t = cyc / TD;
		if (t <= int'(T_INV_MAX)) return 0;
		if (t <= int'(T1_MAX)) return 1;
		if (t <= int'(T2_MAX)) return 2;
		if (t <= int'(T3_MAX)) return 3;
		return 4;
	endfunction

	function automatic logic [7:0] crc8(input logic [7:0] b[$]);
		logic [7:0] c;
		logic fb;
		c = CRC_INIT;
		foreach (b[i]) begin
			for (int j = 7; j >= 0; j--) begin
				fb = c[7] ^ b[i][j];
				c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
			end
		end
		return ~c;
	endfunction

	task send(input logic [7:0] b[$]);
		logic [31:0] v;
		int n;
		pw.delete();
		pl.delete();
		foreach (b[i]) begin
			n = 0;
			do begin
				apb_rd(A_STATUS, v);
				n++;
			end while (v[0] !== 1'b1 && n < 3000);
			if (n >= 3000) num_errors++;
			apb_wr(A_TRANSMIT_BYTE_REGISTER, {24'h0, b[i]});
			apb_wr(A_TRANSMIT_OPCODE_REGISTER, {30'h0, (i == b.size() - 1) ? OP_LAST : OP_MSG});
		end
		wait_quiet();
	endtask

	// decode captured drive pulses: start symbol, then bytes and check byte
	task check_frame(input logic [7:0] b[$]);
		logic [7:0] got, lv, bad;
		int k, c;
		b.push_back(crc8(b));
		while (pl.size() > 0 && pl[0] === 1'b0) begin
			void'(pl.pop_front());
			void'(pw.pop_front());
		end
		chk(pw.size(), 1 + 8 * b.size());
		if (pw.size() == 1 + 8 * b.size()) begin
			chk({pl[0], 3'(cls(pw[0]))}, 4'hB);
			foreach (b[i]) begin
				for (int j = 0; j < 8; j++) begin
					k = 1 + 8 * i + j;
					c = cls(pw[k]);
					lv[7 - j] = pl[k];
					got[7 - j] = pl[k] ? (c == 1) : (c == 2);
					bad[7 - j] = (c != 1 && c != 2);
				end
				chk({bad, lv, got}, {8'h00, 8'h55, b[i]});
			end
		end
		pw.delete();
		pl.delete();
	endtask

	task results;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#600_000;
		num_errors++;
		results();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] v;
		int n;
		repeat (2) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		@(posedge sys_clk_in);
		chk(drive, 0);
		apb_rd(A_STATUS, v);
		chk(v, 32'h1);
		apb_rd(8'h18, v);
		chk({last_err, v[30:0]}, 32'h8000_0000);
		apb_wr(A_FILTER, 32'hFFFF_FFFF);
		apb_wr(A_CTRL, 32'h1 | (DLY << CTRL_DLY));
		apb_rd(A_CTRL, v);
		chk(v, 32'h1 | (DLY << CTRL_DLY));
		ticks(320);
		send('{8'hA5});
		check_frame('{8'hA5});
		apb_rd(A_STATUS, v);
		chk(v[1], 1'b1);
		apb_rd(A_RECEIVE_BYTE_REGISTER, v);
		chk(v, {24'h0, crc8('{8'hA5})});
		apb_wr(A_FILTER, 32'h0);
		send('{8'h3C, 8'hC3});
		check_frame('{8'h3C, 8'hC3});
		apb_rd(A_STATUS, v);
		chk(v[1], 1'b0);
		// inverted pin polarity
		apb_wr(A_CTRL, 32'h3 | (DLY << CTRL_DLY));
		inv <= 1'b1;
		ticks(320);
		send('{8'h00, 8'hFF});
		check_frame('{8'h00, 8'hFF});
		apb_wr(A_CTRL, 32'h1 | (DLY << CTRL_DLY));
		inv <= 1'b0;
		ticks(320);
		// foreign zero beats our one in the first bit
		apb_wr(A_TRANSMIT_BYTE_REGISTER, 32'hD5);
		apb_wr(A_TRANSMIT_OPCODE_REGISTER, 32'(OP_LAST));
		wait_lvl(1'b1, n);
		wait_lvl(1'b0, n);
		// let the recorder close the start symbol before clearing it
		@(posedge sys_clk_in);
		pw.delete();
		pl.delete();
		ticks(50);
		other <= 1'b1;
		ticks(64);
		other <= 1'b0;
		wait_quiet();
		chk(pw.size(), 0);
		apb_rd(A_STATUS, v);
		chk(v[3:2], 2'b10);
		apb_wr(A_STATUS, 32'h8);
		apb_rd(A_STATUS, v);
		chk(v[3], 1'b0);
		apb_wr(A_TRANSMIT_OPCODE_REGISTER, 32'(OP_LAST));
		wait_quiet();
		check_frame('{8'hD5});
		// glitch is dropped, short pulse is an invalid bit
		other <= 1'b1;
		ticks(4);
		other <= 1'b0;
		ticks(50);
		apb_rd(A_STATUS, v);
		chk(v[2], 1'b0);
		other <= 1'b1;
		ticks(20);
		other <= 1'b0;
		ticks(50);
		apb_rd(A_STATUS, v);
		chk(v[2], 1'b1);
		apb_wr(A_STATUS, 32'h4);
		ticks(320);
		// queued too late into a foreign start symbol
		apb_wr(A_TRANSMIT_BYTE_REGISTER, 32'h3C);
		other <= 1'b1;
		ticks(150);
		apb_wr(A_TRANSMIT_OPCODE_REGISTER, 32'(OP_LAST));
		apb_rd(A_STATUS, v);
		chk({drive, v[0]}, 2'b00);
		ticks(44);
		other <= 1'b0;
		wait_lvl(1'b1, n);
		chk(32'(n / TD > 280 && n / TD < 330), 1);
		wait_quiet();
		check_frame('{8'h3C});
		// queued early enough to join a foreign start symbol
		apb_wr(A_TRANSMIT_BYTE_REGISTER, 32'h3C);
		other <= 1'b1;
		ticks(30);
		apb_wr(A_TRANSMIT_OPCODE_REGISTER, 32'(OP_LAST));
		ticks(20);
		chk(drive, 1);
		wait_lvl(1'b0, n);
		other <= 1'b0;
		wait_quiet();
		apb_rd(A_STATUS, v);
		chk(v[3:2], 2'b00);
		results();
	end
endmodule // vpwc_codec_test
`default_nettype wire
